// ===== mlc_consts.svh
`ifndef MLC_CONSTS_SVH
`define MLC_CONSTS_SVH

// ==========================================
// register map
`define MLC_ADDR_HIGH   2'h0
`define MLC_ADDR_LOW    2'h1

// ==========================================
// field positions
`define MLC_BIT_ODIS    7
`define MLC_BIT_INVERT  6
`define MLC_BIT_SYNC    5
`define MLC_BIT_UNUSED  4
`define MLC_SEL_MSB     3

// ==========================================
// values
`define MLC_CTL_RESET   8'h00
`define MLC_WR_MASK     8'hEF
`define MLC_SEL_VSS     4'h0
`define MLC_SEL_REFCLK  4'h3

`endif

// ===== mlc_pkg.sv
package mlc_pkg;
	typedef enum logic [1:0] {
		MLC_ST_LOW  = 2'b01,
		MLC_ST_HIGH = 2'b10
	} mlc_state_t;
	typedef logic [7:0] mlc_ctl_t;
	typedef logic [3:0] mlc_sel_t;
endpackage

// ===== mlc_if.sv
`timescale 1ns/100ps
interface mlc_if;
	logic [3:0] sel;
	logic       invert;
	logic [7:0] srcs;
	logic [3:0] pwm_ok;
	logic       carrier;
	logic       fall;
	modport ctl  (output sel, output invert, output srcs, output pwm_ok, input carrier, input fall);
	modport path (input sel, input invert, input srcs, input pwm_ok, output carrier, output fall);
endinterface

// ===== mlc_path.sv
`timescale 1ns/100ps
`include "mlc_consts.svh"
module mlc_path
	import mlc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	mlc_if.path      cif
);
	logic carrier_reg;
	logic carrier_next;
	logic prev_reg;
	logic raw;

	// ==========================================
	// source select and polarity
	always_comb
	begin
		raw = 1'b0;
		if (cif.sel[`MLC_SEL_MSB])
			raw = 1'b0;
		else if (cif.sel == `MLC_SEL_VSS)
			raw = 1'b0;
		else if (cif.sel[2])
			raw = cif.srcs[cif.sel[2:0]] & cif.pwm_ok[cif.sel[1:0]];
		else
			raw = cif.srcs[cif.sel[2:0]];
		carrier_next = raw ^ cif.invert;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			carrier_reg <= 1'b0;
			prev_reg    <= 1'b0;
		end
		else
		begin
			carrier_reg <= carrier_next;
			prev_reg    <= carrier_reg;
		end
	end

	assign cif.carrier = carrier_reg;
	assign cif.fall    = prev_reg & ~carrier_reg;

	// ==========================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_invert_refclk: assert property ((cif.sel == `MLC_SEL_REFCLK) |=>
		carrier_reg == ($past(cif.invert) ^ $past(cif.srcs[3])))
		else $error("refclk carrier polarity wrong");
	a_reserved_none: assert property (cif.sel[`MLC_SEL_MSB] |=> carrier_reg == $past(cif.invert))
		else $error("reserved code passed a channel");
	a_vss_pwm_gate: assert property (((cif.sel == `MLC_SEL_VSS) ||
		(cif.sel[3:2] == 2'b01 && !cif.pwm_ok[cif.sel[1:0]])) |=> carrier_reg == $past(cif.invert))
		else $error("vss or non-pwm source not held low");
endmodule

// ===== mlc_top.sv
// Functional notes
// - output-disable bit set turns off the selected low source's pin drive
// - invert bit set inverts the selected low carrier, else passes it
// - sync bit set: low-to-high switch waits for low carrier falling edge
// - four-bit selector; codes 1000 to 1111 connect no channel
// - without sync, switching is immediate and may clip carrier pulses
// - code 0000 is low, 0011 reference clock, 0100-0111 pwm outputs
// - high sync bit set: high-to-low switch waits for high falling edge
`timescale 1ns/100ps
`include "mlc_consts.svh"
module mlc_top
	import mlc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  wire logic [7:1] carrier_src_in,
	input  wire logic [3:0] pwm_mode_in,
	input  wire logic       mod_data_in,
	output logic            mod_out,
	output logic            carrier_high_active,
	output logic      [7:1] src_oe
);
	mlc_ctl_t   low_reg;
	mlc_ctl_t   low_next;
	mlc_ctl_t   high_reg;
	mlc_ctl_t   high_next;
	mlc_ctl_t   rdata_reg;
	mlc_ctl_t   rdata_next;
	logic [7:1] src_s1_reg;
	logic [7:1] src_s2_reg;
	mlc_state_t state_reg;
	mlc_state_t state_next;
	logic       mod_out_reg;
	logic       mod_out_next;
	logic [7:1] oe_reg;
	logic [7:1] oe_next;
	logic       lo_car;
	logic       lo_fall;
	logic       hi_car;
	logic       hi_fall;

	// ==========================================
	// register file
	always_comb
	begin
		low_next   = low_reg;
		high_next  = high_reg;
		rdata_next = rdata_reg;
		if (wr_en && addr == `MLC_ADDR_LOW)
			low_next = wdata & `MLC_WR_MASK;
		else if (wr_en && addr == `MLC_ADDR_HIGH)
			high_next = wdata & `MLC_WR_MASK;
		if (rd_en && addr == `MLC_ADDR_LOW)
			rdata_next = low_reg;
		else if (rd_en && addr == `MLC_ADDR_HIGH)
			rdata_next = high_reg;
		else if (rd_en)
			rdata_next = 8'h00;
	end

	// ==========================================
	// carrier paths, one per carrier
	mlc_if cif[2] ();
	assign cif[0].sel    = low_reg[`MLC_SEL_MSB:0];
	assign cif[0].invert = low_reg[`MLC_BIT_INVERT];
	assign cif[1].sel    = high_reg[`MLC_SEL_MSB:0];
	assign cif[1].invert = high_reg[`MLC_BIT_INVERT];
	assign lo_car  = cif[0].carrier;
	assign lo_fall = cif[0].fall;
	assign hi_car  = cif[1].carrier;
	assign hi_fall = cif[1].fall;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_path
			assign cif[g].srcs   = {src_s2_reg, 1'b0};
			assign cif[g].pwm_ok = pwm_mode_in;
			mlc_path u_path (
				.clk   (clk),
				.rst_n (rst_n),
				.cif   (cif[g])
			);
		end
	endgenerate

	// ==========================================
	// carrier switching
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			MLC_ST_LOW:
				if (mod_data_in && (!low_reg[`MLC_BIT_SYNC] || lo_fall))
					state_next = MLC_ST_HIGH;
			MLC_ST_HIGH:
				if (!mod_data_in && (!high_reg[`MLC_BIT_SYNC] || hi_fall))
					state_next = MLC_ST_LOW;
			default:
				state_next = MLC_ST_LOW;
		endcase
		mod_out_next = (state_reg == MLC_ST_HIGH) ? hi_car : lo_car;
	end

	// ==========================================
	// pin drive enables
	always_comb
	begin
		for (int k = 1; k < 8; k++)
		begin
			// high carrier disable shares the same pins
			oe_next[k] = !((low_reg[`MLC_BIT_ODIS] && low_reg[`MLC_SEL_MSB:0] == 4'(k)) ||
				(high_reg[`MLC_BIT_ODIS] && high_reg[`MLC_SEL_MSB:0] == 4'(k)));
		end
	end

	always_ff @(posedge clk)
	begin
		// sources come from pins of other blocks; two flops before use
		src_s1_reg <= carrier_src_in;
		src_s2_reg <= src_s1_reg;
		if (!rst_n)
		begin
			// power-on value is unknown in silicon; zero keeps sim defined
			low_reg     <= `MLC_CTL_RESET;
			high_reg    <= `MLC_CTL_RESET;
			rdata_reg   <= 8'h00;
			state_reg   <= MLC_ST_LOW;
			mod_out_reg <= 1'b0;
			oe_reg      <= 7'h7F;
		end
		else
		begin
			low_reg     <= low_next;
			high_reg    <= high_next;
			rdata_reg   <= rdata_next;
			state_reg   <= state_next;
			mod_out_reg <= mod_out_next;
			oe_reg      <= oe_next;
		end
	end

	assign rdata               = rdata_reg;
	assign mod_out             = mod_out_reg;
	assign carrier_high_active = state_reg[1];
	assign src_oe              = oe_reg;

	// ==========================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_odis_low_pin: assert property ((low_reg[`MLC_BIT_ODIS] && !low_reg[3] && low_reg[2:0] != 3'h0)
		|=> !oe_reg[$past(low_reg[2:0])])
		else $error("disabled low source pin still driven");
	a_oe_all_on: assert property ((!low_reg[`MLC_BIT_ODIS] && !high_reg[`MLC_BIT_ODIS]) |=> oe_reg == 7'h7F)
		else $error("pin drive dropped without disable");
	a_sync_low_wait: assert property ((state_reg == MLC_ST_LOW && low_reg[`MLC_BIT_SYNC] && !lo_fall)
		|=> state_reg == MLC_ST_LOW)
		else $error("switched to high without low falling edge");
	a_nosync_switch: assert property ((state_reg == MLC_ST_LOW && mod_data_in && !low_reg[`MLC_BIT_SYNC])
		|=> state_reg == MLC_ST_HIGH)
		else $error("unsynchronised switch delayed");
	a_sync_edge_go: assert property ((state_reg == MLC_ST_LOW && mod_data_in && lo_fall)
		|=> state_reg == MLC_ST_HIGH)
		else $error("falling edge did not release switch");
	a_sync_high_wait: assert property ((state_reg == MLC_ST_HIGH && high_reg[`MLC_BIT_SYNC] && !hi_fall)
		|=> state_reg == MLC_ST_HIGH)
		else $error("switched to low without high falling edge");
	a_bit4_zero: assert property (rd_en |=> rdata_reg[`MLC_BIT_UNUSED] == 1'b0)
		else $error("unused bit read nonzero");
	a_low_readback: assert property ((wr_en && addr == `MLC_ADDR_LOW) ##1 (rd_en && addr == `MLC_ADDR_LOW && !wr_en)
		|=> rdata_reg == ($past(wdata, 2) & `MLC_WR_MASK))
		else $error("low control readback wrong");
	a_bit4_hold: assert property ((wr_en && addr == `MLC_ADDR_LOW) |=> low_reg[`MLC_BIT_UNUSED] == 1'b0)
		else $error("unused bit stored a one");
	a_odis_high_pin: assert property ((high_reg[`MLC_BIT_ODIS] && !high_reg[3] && high_reg[2:0] != 3'h0)
		|=> !oe_reg[$past(high_reg[2:0])])
		else $error("disabled high source pin still driven");
	// vss and reserved codes own no pin, so a disable there must change nothing
	a_vss_no_pin: assert property ((!high_reg[`MLC_BIT_ODIS] && low_reg[`MLC_BIT_ODIS]
		&& low_reg[`MLC_SEL_MSB:0] == `MLC_SEL_VSS) |=> oe_reg == 7'h7F)
		else $error("constant low source dropped a pin drive");

	// ==========================================
	// switching and output checks
	a_low_hold: assert property ((state_reg == MLC_ST_LOW && !mod_data_in) |=> state_reg == MLC_ST_LOW)
		else $error("left low carrier without request");
	a_low_fall_flag: assert property (lo_fall == ($past(lo_car) && !lo_car))
		else $error("low falling edge flag wrong");
	a_high_hold: assert property ((state_reg == MLC_ST_HIGH && mod_data_in) |=> state_reg == MLC_ST_HIGH)
		else $error("left high carrier without request");
	a_high_nosync: assert property ((state_reg == MLC_ST_HIGH && !mod_data_in && !high_reg[`MLC_BIT_SYNC])
		|=> state_reg == MLC_ST_LOW)
		else $error("unsynchronised high to low switch delayed");
	a_high_edge_go: assert property ((state_reg == MLC_ST_HIGH && !mod_data_in && hi_fall)
		|=> state_reg == MLC_ST_LOW)
		else $error("high falling edge did not release switch");
	a_mod_out_low: assert property ((state_reg == MLC_ST_LOW) |=> mod_out_reg == $past(lo_car))
		else $error("output does not follow low carrier");
	a_mod_out_high: assert property ((state_reg == MLC_ST_HIGH) |=> mod_out_reg == $past(hi_car))
		else $error("output does not follow high carrier");

	// ==========================================
	// cover points
	c_sync_switch: cover property (state_reg == MLC_ST_LOW && low_reg[`MLC_BIT_SYNC] && lo_fall && mod_data_in);
	c_high_back: cover property (state_reg == MLC_ST_HIGH ##1 state_reg == MLC_ST_LOW);
	c_pin_off: cover property (oe_reg != 7'h7F);
	c_pwm_pass: cover property (low_reg[3:2] == 2'b01 && pwm_mode_in[low_reg[1:0]]);
	c_refclk_sel: cover property (low_reg[`MLC_SEL_MSB:0] == `MLC_SEL_REFCLK);
endmodule

// ===== mlc_src_model.sv
`timescale 1ns/100ps
// ==========
// carrier sources
module mlc_src_model
(
	input  wire logic       clk,
	output logic      [7:1] src
);
	logic [9:0] cnt_reg = 10'h000;
	always_ff @(posedge clk)
		cnt_reg <= cnt_reg + 10'h001;
	// delayed so source edges never meet the sampling edge
	assign #3 src = cnt_reg[9:3];
endmodule

// ===== modulator_low_carrier_control_tb.sv
`timescale 1ns/100ps
// ==========
// bench
module modulator_low_carrier_control_tb;
	import mlc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] addr, a;
	logic wr_en, rd_en, mod_data_in, mod_out, cha;
	logic [3:0] pwm_mode_in;
	logic [7:1] src, src_oe;
	mlc_ctl_t wdata, rdata, hi_sh, lo_sh, d;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int seed = 32'hCBE0;
	int i;
	int j;
	logic ex;
	logic [7:1] h1, h2, h3, h4, h5;
	initial forever #5 clk = ~clk;
	mlc_src_model u_src (.clk(clk), .src(src));
	mlc_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .carrier_src_in(src), .pwm_mode_in(pwm_mode_in), .mod_data_in(mod_data_in),
		.mod_out(mod_out), .carrier_high_active(cha), .src_oe(src_oe));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask
	task give_verdict;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input logic [1:0] aa, input mlc_ctl_t dd);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= aa;
		wdata <= dd;
		@(posedge clk);
		wr_en <= 1'b0;
		if (aa == 2'h0) hi_sh = dd & 8'hEF;
		if (aa == 2'h1) lo_sh = dd & 8'hEF;
	endtask
	task rd_chk(input logic [1:0] aa, input mlc_ctl_t e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= aa;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	// write, then read the same address in the very next cycle
	task wr_rd(input logic [1:0] aa, input mlc_ctl_t dd);
		wr(aa, dd);
		rd_en <= 1'b1;
		addr <= aa;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk("rdata_b2b", exp_rd(aa), rdata);
	endtask
	// source history: h4 is what reaches mod_out now, after sync, mux and output flops
	always @(posedge clk)
	begin
		h1 <= src;
		h2 <= h1;
		h3 <= h2;
		h4 <= h3;
		h5 <= h4;
	end
	function mlc_ctl_t exp_rd(input logic [1:0] aa);
		exp_rd = (aa == 2'h0) ? hi_sh : (aa == 2'h1) ? lo_sh : 8'h00;
	endfunction
	function logic [7:1] exp_oe;
		exp_oe = 7'h7F;
		if (hi_sh[7] && hi_sh[3:0] inside {[1:7]}) exp_oe[hi_sh[2:0]] = 1'b0;
		if (lo_sh[7] && lo_sh[3:0] inside {[1:7]}) exp_oe[lo_sh[2:0]] = 1'b0;
	endfunction
	always @(posedge clk)
	begin
		cyc++;
		// well above the roughly 750 cycles the tests take
		if (cyc == 5000)
		begin
			err_total++;
			give_verdict();
		end
	end
	initial
	begin
		addr = 2'h0; wdata = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
		pwm_mode_in = 4'h0; mod_data_in = 1'b0; hi_sh = 8'h00; lo_sh = 8'h00;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 4; i++)
			rd_chk(i[1:0], 8'h00);
		$display("test reset done");
		for (i = 0; i < 40; i++)
		begin
			a = 2'($random(seed));
			d = (i < 4) ? 8'hFF - i[7:0] : 8'($random(seed));
			@(posedge clk);
			pwm_mode_in <= 4'($random(seed));
			wr(a, d);
			@(posedge clk);
			#1 chk("src_oe", {1'b0, exp_oe()}, {1'b0, src_oe});
			rd_chk(a, exp_rd(a));
		end
		for (i = 0; i < 8; i++)
			wr_rd(i[1:0], 8'($random(seed)));
		$display("test registers done");
		@(posedge clk);
		pwm_mode_in <= 4'h0;
		wr(2'h0, 8'h00);
		for (i = 0; i < 32; i++)
			if (i[3:0] == 4'h0 || i[3:0] > 4'h3)
			begin
				wr(2'h1, {1'b0, i[4], 2'b00, i[3:0]});
				repeat (5) @(posedge clk);
				#1 chk("mod_out", {7'h00, i[4]}, {7'h00, mod_out});
			end
		$display("test carrier done");
		// inverted constant low source never falls, so a synced switch must hang
		wr(2'h0, 8'h60);
		wr(2'h1, 8'h60);
		mod_data_in <= 1'b1;
		repeat (20) @(posedge clk);
		#1 chk("high_active", 8'h00, {7'h00, cha});
		wr(2'h1, 8'h40);
		repeat (4) @(posedge clk);
		#1 chk("high_active", 8'h01, {7'h00, cha});
		chk("mod_out", 8'h01, {7'h00, mod_out});
		@(posedge clk);
		mod_data_in <= 1'b0;
		repeat (20) @(posedge clk);
		#1 chk("high_active", 8'h01, {7'h00, cha});
		wr(2'h0, 8'h00);
		repeat (4) @(posedge clk);
		#1 chk("high_active", 8'h00, {7'h00, cha});
		// low source 1 toggles, so the synced switch waits for its falling edge
		wr(2'h1, 8'h21);
		repeat (8) @(posedge clk);
		mod_data_in <= 1'b1;
		ex = 1'b0;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk);
			#1 ex = ex | (!h4[1] & h5[1]);
			chk("sync_release", {7'h00, ex}, {7'h00, cha});
		end
		chk("high_active", 8'h01, {7'h00, cha});
		@(posedge clk);
		mod_data_in <= 1'b0;
		$display("test sync done");
		pwm_mode_in <= 4'hF;
		for (i = 1; i < 8; i++)
		begin
			wr(2'h1, {1'b0, i[0], 3'b000, i[2:0]});
			repeat (3) @(posedge clk);
			for (j = 0; j < 20; j++)
			begin
				@(posedge clk);
				#1 chk("mod_out_src", {7'h00, h4[i] ^ i[0]}, {7'h00, mod_out});
			end
		end
		$display("test sources done");
		give_verdict();
	end
endmodule
